// file: core/sec_pkg.sv
package sec_pkg;

  // clock and programming time
  localparam int CLK_MHZ    = 200;               // core clock rate
  localparam int TEW_US     = 10000;             // self-timed cycle, 10 ms
  localparam int TEW_CYCLES = TEW_US * CLK_MHZ;  // longest time, exact product
  localparam int TMR_W      = 21;                // width of the cycle timer

  // instruction field lengths
  localparam int OPC_BITS     = 2;               // opcode bits after start bit
  localparam int ADDR_BITS_16 = 7;               // address bits, 16-bit words
  localparam int ADDR_BITS_8  = 8;               // address bits, byte words
  localparam int DATA_BITS_16 = 16;              // data bits, 16-bit words
  localparam int DATA_BITS_8  = 8;               // data bits, byte words

  // opcodes and sub-commands
  localparam logic [1:0] OP_READ  = 2'h2;        // read word
  localparam logic [1:0] OP_ERASE = 2'h3;        // erase word
  localparam logic [1:0] OP_WRITE = 2'h1;        // write word
  localparam logic [1:0] OP_MISC  = 2'h0;        // sub-command in address
  localparam logic [1:0] SUB_EN   = 2'h3;        // program_enable_cmd
  localparam logic [1:0] SUB_DIS  = 2'h0;        // program_disable_cmd
  localparam logic [1:0] SUB_ERASE_EVERY_WORD_CMD = 2'h2;        // erase_every_word_cmd
  localparam logic [1:0] SUB_WRITE_EVERY_WORD_CMD = 2'h1;        // write_every_word_cmd

  // array
  localparam logic [15:0] ERASED_WORD = 16'hffff; // erased cells read ones
  localparam logic [6:0]  LAST_WORD   = 7'h7f;    // 128 physical words

  // link side states
  typedef enum logic [5:0] {
    L_HUNT = 6'h01,                              // waiting for start bit
    L_OPC  = 6'h02,                              // opcode bits
    L_ADDR = 6'h04,                              // address bits
    L_DATA = 6'h08,                              // write data bits
    L_READ = 6'h10,                              // shifting read data out
    L_DONE = 6'h20                               // instruction complete
  } sec_lstate_t;

  // core side states
  typedef enum logic [2:0] {
    C_IDLE  = 3'h1,                              // ready
    C_SWEEP = 3'h2,                              // writing the array
    C_TIMED = 3'h4                               // self-timed wait
  } sec_cstate_t;

  typedef struct packed {
    logic [1:0]  op;                             // opcode
    logic [7:0]  addr;                           // address field
    logic [15:0] data;                           // data field
  } sec_cmd_t;

  typedef struct packed {
    sec_lstate_t state;                          // decoder state
    logic [4:0]  cnt;                            // bit counter in a phase
    sec_cmd_t    cmd;                            // collected instruction
    logic        org_s1;                         // width level, first stage
    logic        org_s2;                         // width level, second stage
    logic        started;                        // start bit seen
    logic        done;                           // instruction complete
    logic        rd_req;                         // read address complete
    logic        rd_active;                      // output driven for read
    logic        rd_bit;                         // output bit for read
  } sec_link_t;

  localparam sec_link_t SEC_LINK_RST = '{
    state: L_HUNT, cnt: 5'h00, cmd: '0, org_s1: 1'b1, org_s2: 1'b1,
    started: 1'b0, done: 1'b0, rd_req: 1'b0, rd_active: 1'b0, rd_bit: 1'b0};

  typedef struct packed {
    sec_cstate_t state;                          // sequencer state
    logic        prog_en;                        // programming allowed
    logic        org16;                          // 16-bit word arrangement
    sec_cmd_t    pend;                           // accepted program command
    logic        pend_valid;                     // waiting for select low
    logic        all_op;                         // whole-array operation
    logic        wipe;                           // store erased value
    logic [6:0]  sw_addr;                        // sweep word pointer
    logic [6:0]  last_addr;                      // sweep end
    logic [TMR_W-1:0] tmr;                       // programming timer
    logic        status_show;                    // busy/ready on output
    logic        rd_pend;                        // read waiting for port
    logic        rd_cap;                         // memory data due
    logic        rd_lane;                        // upper byte selected
    logic [15:0] rd_word;                        // word for the link
    logic        dout;                           // serial output level
    logic        doe;                            // serial output enable
  } sec_core_t;

  localparam sec_core_t SEC_CORE_RST = '{
    state: C_IDLE, prog_en: 1'b0, org16: 1'b1, pend: '0, pend_valid: 1'b0,
    all_op: 1'b0, wipe: 1'b0, sw_addr: 7'h00, last_addr: 7'h00, tmr: '0,
    status_show: 1'b0, rd_pend: 1'b0, rd_cap: 1'b0, rd_lane: 1'b0,
    rd_word: 16'h0000, dout: 1'b0, doe: 1'b0};

  // sub-command sits in the two leading address bits
  function automatic logic [1:0] sub_cmd(input logic org16, input logic [7:0] addr);
    sub_cmd = org16 ? addr[6:5] : addr[7:6];
  endfunction : sub_cmd

  // physical word holding an address
  function automatic logic [6:0] word_index(input logic org16, input logic [7:0] addr);
    word_index = org16 ? addr[6:0] : addr[7:1];
  endfunction : word_index

  // byte lanes touched by a write
  function automatic logic [1:0] lane_mask(input logic org16, input logic odd,
                                           input logic all_op);
    if (org16 || all_op) begin
      lane_mask = 2'h3;
    end else begin
      lane_mask = odd ? 2'h2 : 2'h1;
    end
  endfunction : lane_mask

endpackage : sec_pkg

// file: core/sec_mem.sv
module sec_mem
  import sec_pkg::*;
(
  input  wire logic        clock_in,   // core clock
  input  wire logic [1:0]  we_in,      // byte lane write enables
  input  wire logic [6:0]  addr_in,    // word address
  input  wire logic [15:0] wdata_in,   // write data
  output logic      [15:0] rdata_out   // registered read data
);

  logic [15:0] cells [0:127];          // cell array, no reset

  // one write port per byte lane
  genvar lane;
  generate
    for (lane = 0; lane < 2; lane++) begin : g_lane
      always_ff @(posedge clock_in) begin
        if (we_in[lane]) begin
          cells[addr_in][lane*8 +: 8] <= wdata_in[lane*8 +: 8];
        end
      end
    end
  endgenerate

  // read data leave through a register
  always_ff @(posedge clock_in) begin
    rdata_out <= cells[addr_in];
  end

endmodule : sec_mem

// file: core/sec_top.sv
// Notes on behaviour
// - strap high gives 128 words of 16
// - strap low gives 256 words of 8
// - open strap pulled high, 16-bit words; no pull-up here, an open strap loads org16 as unknown
// - data only bit-serial in and out
// - read: start, 10, then address bits
// - erase: start, 11, address; erases word
// - write: start, 01, address, data MSB first
// - opcode 00: address top bits pick sub-command
// - self-timed cycle, write overwrites without erase
// - input sampled on serial clock rising edge
// - read: dummy zero, then data bits
// - programming off at power-up until enabled
// - selected after programming: low busy, high ready
module sec_top
  import sec_pkg::*;
#(
  parameter int TEW_CYC = TEW_CYCLES                  // self-timed cycle in clocks
) (
  input  wire logic clock_in,                         // core clock, 200 MHz
  input  wire logic rst_n_in,                         // sync reset, active low
  input  wire logic chip_select_in,                   // chip select, active high
  input  wire logic serial_shift_clock_in,            // link clock from host
  input  wire logic serial_input_line_in,             // serial data in
  input  wire logic word_width_strap_in,              // high: 16-bit words
  output logic      serial_output_line_out,           // serial data out
  output logic      serial_output_line_oe_out         // output enable, high drives
);

  sec_link_t   lr;                                    // link registers
  sec_link_t   next_lr;                               // link next values
  sec_core_t   cr;                                    // core registers
  sec_core_t   next_cr;                               // core next values
  logic [4:0]  alen;                                  // address length
  logic [4:0]  dlen;                                  // data length
  logic [7:0]  a_shift;                               // address after shift
  logic [5:0]  sync1;                                 // crossing, first stage
  logic [5:0]  sync2;                                 // crossing, second stage
  logic [5:0]  sync3;                                 // edge history
  logic        strap_s1;                              // strap, first stage
  logic        strap_s2;                              // strap, second stage
  logic        cs_fall;                               // select went low
  logic        done_rise;                             // instruction arrived
  logic        rdq_rise;                              // read address arrived
  logic        st_rise;                               // start bit arrived
  logic [1:0]  mem_we;                                // array lane enables
  logic [6:0]  mem_addr;                              // array address
  logic [15:0] mem_wdata;                             // array write data
  logic [15:0] mem_q;                                 // array read data

  // ---------------- link domain ----------------

  // decoder next values, one bit per serial clock edge
  always_comb begin
    next_lr        = lr;
    next_lr.org_s1 = cr.org16;
    next_lr.org_s2 = lr.org_s1;
    alen    = lr.org_s2 ? 5'(ADDR_BITS_16) : 5'(ADDR_BITS_8);
    dlen    = lr.org_s2 ? 5'(DATA_BITS_16) : 5'(DATA_BITS_8);
    a_shift = {lr.cmd.addr[6:0], serial_input_line_in};
    case (lr.state)
      L_HUNT: begin
        // zeros before the start bit are dropped
        if (serial_input_line_in) begin
          next_lr.started = 1'b1;
          next_lr.state   = L_OPC;
          next_lr.cnt     = 5'h00;
        end
      end
      L_OPC: begin
        next_lr.cmd.op = {lr.cmd.op[0], serial_input_line_in};
        next_lr.cnt    = lr.cnt + 5'h01;
        if (lr.cnt == 5'(OPC_BITS - 1)) begin
          next_lr.state = L_ADDR;
          next_lr.cnt   = 5'h00;
        end
      end
      L_ADDR: begin
        next_lr.cmd.addr = a_shift;
        next_lr.cnt      = lr.cnt + 5'h01;
        if (lr.cnt == alen - 5'h01) begin
          next_lr.cnt = 5'h00;
          if (lr.cmd.op == OP_READ) begin
            // output leaves high impedance with the dummy zero
            next_lr.state     = L_READ;
            next_lr.rd_req    = 1'b1;
            next_lr.rd_active = 1'b1;
            next_lr.rd_bit    = 1'b0;
          end else if (lr.cmd.op == OP_WRITE ||
                       (lr.cmd.op == OP_MISC &&
                        sub_cmd(lr.org_s2, a_shift) == SUB_WRITE_EVERY_WORD_CMD)) begin
            next_lr.state = L_DATA;
          end else begin
            next_lr.state = L_DONE;
            next_lr.done  = 1'b1;
          end
        end
      end
      L_DATA: begin
        // data field, most significant bit first
        next_lr.cmd.data = {lr.cmd.data[14:0], serial_input_line_in};
        next_lr.cnt      = lr.cnt + 5'h01;
        if (lr.cnt == dlen - 5'h01) begin
          next_lr.state = L_DONE;
          next_lr.done  = 1'b1;
        end
      end
      L_READ: begin
        // one data bit per rising edge, then release the line
        next_lr.cnt = lr.cnt + 5'h01;
        if (lr.cnt == dlen) begin
          next_lr.rd_active = 1'b0;
          next_lr.state     = L_DONE;
        end else begin
          next_lr.rd_bit = cr.rd_word[4'(dlen - 5'h01 - lr.cnt)];
        end
      end
      L_DONE: begin
        next_lr.state = L_DONE;                              // extra clocks ignored
      end
      default: begin
        next_lr = SEC_LINK_RST;
      end
    endcase
  end

  // link registers; select low clears the decoder at once
  always_ff @(posedge serial_shift_clock_in or negedge chip_select_in) begin
    if (!chip_select_in) begin
      lr <= SEC_LINK_RST;
    end else begin
      lr <= next_lr;
    end
  end

  // ---------------- core domain ----------------

  // level crossings into the core clock
  always_ff @(posedge clock_in) begin
    sync1    <= {lr.rd_bit, lr.rd_active, lr.started, lr.rd_req, lr.done,
                 chip_select_in};
    sync2    <= sync1;
    sync3    <= sync2;
    strap_s1 <= word_width_strap_in;
    strap_s2 <= strap_s1;
  end

  assign cs_fall   = sync3[0] & ~sync2[0];
  assign done_rise = sync2[1] & ~sync3[1];
  assign rdq_rise  = sync2[2] & ~sync3[2];
  assign st_rise   = sync2[3] & ~sync3[3];

  // command acceptance, sequencer, read fetch and output pin
  always_comb begin
    next_cr   = cr;
    mem_we    = 2'h0;
    mem_addr  = cr.sw_addr;
    mem_wdata = ERASED_WORD;
    next_cr.rd_cap = 1'b0;
    // instruction word stays stable while done is high
    if (done_rise) begin
      if (lr.cmd.op == OP_MISC && sub_cmd(cr.org16, lr.cmd.addr) == SUB_EN) begin
        next_cr.prog_en = 1'b1;
      end else if (lr.cmd.op == OP_MISC &&
                   sub_cmd(cr.org16, lr.cmd.addr) == SUB_DIS) begin
        next_cr.prog_en = 1'b0;
      end else if (lr.cmd.op != OP_READ && cr.prog_en && cr.state == C_IDLE) begin
        // program commands only while enabled and idle
        next_cr.pend       = lr.cmd;
        next_cr.pend_valid = 1'b1;
        next_cr.all_op     = (lr.cmd.op == OP_MISC);
        next_cr.wipe       = (lr.cmd.op == OP_ERASE) ||
                             (lr.cmd.op == OP_MISC &&
                              sub_cmd(cr.org16, lr.cmd.addr) == SUB_ERASE_EVERY_WORD_CMD);
        next_cr.sw_addr    = (lr.cmd.op == OP_MISC) ? 7'h00 :
                             word_index(cr.org16, lr.cmd.addr);
        next_cr.last_addr  = (lr.cmd.op == OP_MISC) ? LAST_WORD :
                             word_index(cr.org16, lr.cmd.addr);
      end
    end
    // a start bit releases the status display
    if (st_rise) begin
      next_cr.status_show = 1'b0;
    end
    case (cr.state)
      C_IDLE: begin
        // select low after a complete command starts the cycle
        if (cs_fall && cr.pend_valid) begin
          next_cr.state       = C_SWEEP;
          next_cr.pend_valid  = 1'b0;
          next_cr.status_show = 1'b1;
        end
      end
      C_SWEEP: begin
        // a write overwrites the lane, so no prior erase is needed
        mem_we    = lane_mask(cr.org16, cr.pend.addr[0], cr.all_op);
        mem_wdata = cr.wipe ? ERASED_WORD :
                    (cr.org16 ? cr.pend.data : {cr.pend.data[7:0], cr.pend.data[7:0]});
        if (cr.sw_addr == cr.last_addr) begin
          next_cr.state = C_TIMED;
          next_cr.tmr   = '0;
        end else begin
          next_cr.sw_addr = cr.sw_addr + 7'h01;
        end
      end
      C_TIMED: begin
        // self-timed wait, no serial clock needed
        next_cr.tmr = cr.tmr + TMR_W'(1);
        if (cr.tmr == TMR_W'(TEW_CYC - 1)) begin
          next_cr.state = C_IDLE;
        end
      end
      default: begin
        next_cr.state = C_IDLE;
      end
    endcase
    // read fetch waits while the sweep owns the port; reads ignore enable
    if (cr.rd_pend && cr.state != C_SWEEP) begin
      mem_addr        = word_index(cr.org16, lr.cmd.addr);
      next_cr.rd_pend = 1'b0;
      next_cr.rd_cap  = 1'b1;
      next_cr.rd_lane = lr.cmd.addr[0];
    end
    if (rdq_rise) begin
      next_cr.rd_pend = 1'b1;
    end
    if (cr.rd_cap) begin
      next_cr.rd_word = cr.org16 ? mem_q :
                        {8'h00, (cr.rd_lane ? mem_q[15:8] : mem_q[7:0])};
    end
    // output pin: read bits, else status, else released
    if (!sync2[0]) begin
      next_cr.doe  = 1'b0;
      next_cr.dout = 1'b0;
    end else if (sync2[4]) begin
      next_cr.doe  = 1'b1;
      next_cr.dout = sync2[5];
    end else if (cr.status_show) begin
      next_cr.doe  = 1'b1;
      next_cr.dout = (cr.state == C_IDLE);
    end else begin
      next_cr.doe  = 1'b0;
      next_cr.dout = 1'b0;
    end
    // reset: programming disabled, strap caught at release
    if (!rst_n_in) begin
      next_cr       = SEC_CORE_RST;
      next_cr.org16 = strap_s2;
      mem_we        = 2'h0;
    end
  end

  // core registers
  always_ff @(posedge clock_in) begin
    cr <= next_cr;
  end

  // word array
  sec_mem u_mem (
    .clock_in  (clock_in),
    .we_in     (mem_we),
    .addr_in   (mem_addr),
    .wdata_in  (mem_wdata),
    .rdata_out (mem_q)
  );

  // pin drivers come straight from core flip-flops
  assign serial_output_line_out    = cr.dout;
  assign serial_output_line_oe_out = cr.doe;

endmodule : sec_top

// file: sim/sec_monitor.sv
module sec_monitor
  import sec_pkg::*;
#(
  parameter int TEW_CYC = 50                      // self-timed cycle in clocks
) (
  input wire logic clock_in,                      // core clock
  input wire logic rst_n_in,                      // sync reset, active low
  input wire logic chip_select_in,                // chip select
  input wire logic serial_shift_clock_in,         // link clock
  input wire logic serial_output_line_out,        // serial data out
  input wire logic serial_output_line_oe_out      // output enable
);
  logic [21:0] lo_run, next_lo_run;               // cycles driven low, link still
  logic        sk_q, next_sk_q;                   // link clock, last sample

  // run length restarts on any link edge or when not driving low
  always_comb begin
    next_sk_q   = serial_shift_clock_in;
    next_lo_run = lo_run + 22'h1;
    if (!serial_output_line_oe_out || serial_output_line_out ||
        sk_q != serial_shift_clock_in) begin
      next_lo_run = 22'h0;
    end
  end

  // helper registers only
  always_ff @(posedge clock_in) begin
    lo_run <= rst_n_in ? next_lo_run : 22'h0;
    sk_q   <= next_sk_q;
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_sel6;
    chip_select_in [*6];
  endsequence
  sequence s_off6;
    !chip_select_in [*6];
  endsequence
  sequence s_calm6;
    ($stable(serial_shift_clock_in) && chip_select_in) [*6];
  endsequence

  property p_rel_quiet;
    $rose(rst_n_in) |-> !serial_output_line_oe_out && !serial_output_line_out;
  endproperty
  property p_undriven_low;
    !serial_output_line_oe_out |-> !serial_output_line_out;
  endproperty
  property p_desel_off;
    s_off6 |-> !serial_output_line_oe_out;
  endproperty
  property p_fall_release;
    $fell(chip_select_in) |-> ##[1:6] !serial_output_line_oe_out;
  endproperty
  property p_rise_selected;
    $rose(serial_output_line_oe_out) |-> $past(chip_select_in, 2);
  endproperty
  property p_dummy_zero;
    s_sel6 ##0 $rose(serial_output_line_oe_out) |-> !serial_output_line_out;
  endproperty
  property p_status_rises_only;
    s_calm6 ##0 ($past(serial_output_line_oe_out) && serial_output_line_oe_out)
      |-> !$fell(serial_output_line_out);
  endproperty
  property p_busy_bound;
    lo_run <= TEW_CYC + 140;
  endproperty

  a_rel_quiet: assert property (p_rel_quiet) else $error("output active at reset release");
  a_undriven_low: assert property (p_undriven_low) else $error("data high while undriven");
  a_desel_off: assert property (p_desel_off) else $error("output driven while deselected");
  a_fall_release: assert property (p_fall_release) else $error("output kept after select fell");
  a_rise_selected: assert property (p_rise_selected) else $error("output driven unselected");
  a_dummy_zero: assert property (p_dummy_zero) else $error("read did not start with zero");
  a_status_rises_only: assert property (p_status_rises_only) else $error("data fell between edges");
  a_busy_bound: assert property (p_busy_bound) else $error("busy lasted too long");
endmodule : sec_monitor

bind sec_top sec_monitor #(.TEW_CYC(TEW_CYC)) sec_monitor_inst (
  .clock_in(clock_in), .rst_n_in(rst_n_in), .chip_select_in(chip_select_in),
  .serial_shift_clock_in(serial_shift_clock_in),
  .serial_output_line_out(serial_output_line_out),
  .serial_output_line_oe_out(serial_output_line_oe_out));

// file: sim/sec_host.sv
module sec_host (
  output logic      cs_out,                       // chip select
  output logic      sk_out,                       // link clock, still between frames
  output logic      di_out,                       // serial data to device
  input  wire logic so_in,                        // serial data from device
  input  wire logic soe_in                        // device drives so_in
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 60;                       // link half period, far below core rate
  time           t_fall;                          // when select last fell

  initial begin
    cs_out = 1'b0;
    sk_out = 1'b0;
    di_out = 1'b0;
    t_fall = 0;
  end

  // one rising link edge, bit set up half a period before
  task automatic pulse(input logic b);
    di_out = b;
    #HALF sk_out = 1'b1;
    #HALF sk_out = 1'b0;
  endtask : pulse

  // frame: zeros, instruction, then nrd bits after the dummy
  task automatic xfer(input logic [31:0] bits, input int n, input int lead,
                      input int nrd, output logic [16:0] rd);
    rd = 17'h0;
    cs_out = 1'b1;
    #HALF;
    repeat (lead) pulse(1'b0);
    for (int i = n - 1; i >= 0; i--) pulse(bits[i]);
    for (int j = 0; nrd > 0 && j <= nrd; j++) begin
      rd = {rd[15:0], soe_in ? so_in : 1'bx};
      pulse(1'b0);
    end
    cs_out = 1'b0;
    t_fall = $time;
    #(4 * HALF);
  endtask : xfer

  // select without clocks, wait while busy shows low
  task automatic poll(output logic [1:0] st, output int cyc);
    cs_out = 1'b1;
    #40;
    st = {soe_in, so_in};
    for (int t = 0; soe_in && !so_in && t < 4000; t++) #1;
    cyc = int'(($time - t_fall) / 5);
    cs_out = 1'b0;
    #(4 * HALF);
  endtask : poll
endmodule : sec_host

// file: sim/serial_eeprom_command_port_test.sv
module serial_eeprom_command_port_test;
  import sec_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TEW = 400;                       // shortened self-timed cycle
  logic        clock_in, rst_n_in, word_width_strap;           // clock, reset, width strap
  logic        cs, sk, di, so, soe;               // link wires
  logic [15:0] mem [128];                         // expected array
  logic        org16, en;                         // expected width, enable
  int          error_cnt, comparisons;            // counters

  sec_top #(.TEW_CYC(TEW)) sec_top_inst (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .chip_select_in(cs),
    .serial_shift_clock_in(sk), .serial_input_line_in(di),
    .word_width_strap_in(word_width_strap), .serial_output_line_out(so),
    .serial_output_line_oe_out(soe));
  sec_host sec_host_inst (.cs_out(cs), .sk_out(sk), .di_out(di), .so_in(so), .soe_in(soe));

  initial begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end

  task automatic check(input string what, input logic [16:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  // reset with the strap held through it
  task automatic do_reset(input logic strap);
    word_width_strap <= strap;
    rst_n_in <= 1'b0;
    repeat (16) @(posedge clock_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    org16 = strap;
    en = 1'b0;
  endtask : do_reset

  // expected dummy and data of a read
  function automatic logic [16:0] exp_rd(input logic [7:0] a);
    logic [15:0] w;
    w = mem[org16 ? a[6:0] : a[7:1]];
    return org16 ? {1'b0, w} : {9'h0, a[0] ? w[15:8] : w[7:0]};
  endfunction : exp_rd

  // whole-array address carrying a sub-command
  function automatic logic [7:0] sub_a(input logic [1:0] s);
    return org16 ? {1'b0, s, 5'h0} : {s, 6'h0};
  endfunction : sub_a

  // one frame; cut drops trailing bits
  task automatic cmd(input logic [1:0] op, input logic [7:0] a, input logic [15:0] d,
                     input int cut, output logic [16:0] rd);
    int aw, dw, n;
    logic [31:0] b;
    aw = org16 ? 7 : 8;
    dw = org16 ? 16 : 8;
    b = (32'({1'b1, op}) << aw) | 32'(org16 ? {1'b0, a[6:0]} : a);
    n = 3 + aw;
    if (op == OP_WRITE || (op == OP_MISC && a == sub_a(SUB_WRITE_EVERY_WORD_CMD))) begin
      b = (b << dw) | 32'(org16 ? d : {8'h0, d[7:0]});
      n += dw;
    end
    sec_host_inst.xfer(b >> cut, n - cut, $urandom_range(0, 3),
                       (op == OP_READ && cut == 0) ? dw : 0, rd);
  endtask : cmd

  // program command, then busy poll and expected array update
  task automatic prog(input logic [1:0] op, input logic [7:0] a, input logic [15:0] d);
    logic [16:0] rd;
    logic [1:0]  st;
    logic [15:0] v;
    int          cyc, lo;
    cmd(op, a, d, 0, rd);
    sec_host_inst.poll(st, cyc);
    check("status", 17'(st), en ? 17'h2 : 17'h0);
    lo = TEW + (op == OP_MISC ? 128 : 1);
    if (en) begin
      check("busy time", 17'(cyc >= lo && cyc <= lo + 12), 17'h1);
      v = (op == OP_ERASE || a == sub_a(SUB_ERASE_EVERY_WORD_CMD)) ? 16'hffff
        : (org16 ? d : {d[7:0], d[7:0]});
      if (op == OP_MISC) begin
        foreach (mem[i]) mem[i] = v;
      end else if (org16) begin
        mem[a[6:0]] = v;
      end else if (a[0]) begin
        mem[a[7:1]][15:8] = v[15:8];
      end else begin
        mem[a[7:1]][7:0] = v[7:0];
      end
    end
  endtask : prog

  task automatic rd_chk(input logic [7:0] a);
    logic [16:0] rd;
    cmd(OP_READ, a, 16'h0, 0, rd);
    check("read", rd, exp_rd(a));
  endtask : rd_chk

  // enable or disable, don't-care bits random
  task automatic set_en(input logic on);
    logic [16:0] rd;
    cmd(OP_MISC, sub_a(on ? SUB_EN : SUB_DIS) | 8'($urandom_range(0, 31)), 16'h0, 0, rd);
    en = on;
  endtask : set_en

  initial begin
    #450us;
    error_cnt++;
    $display("watchdog expired");
    wrap_up();
  end

  initial begin
    logic [7:0]  a;
    logic [16:0] rd;
    error_cnt = 0;
    comparisons = 0;
    rst_n_in = 1'b0;
    word_width_strap = 1'b1;
    org16 = 1'b1;
    en = 1'b0;
    void'($urandom(32'h1cbcaf54));
    for (int m = 1; m >= 0; m--) begin
      do_reset(m[0]);
      check("idle enable", 17'(soe), 17'h0);
      prog(OP_WRITE, 8'h04, 16'($urandom));
      set_en(1'b1);
      prog(OP_MISC, sub_a(SUB_ERASE_EVERY_WORD_CMD), 16'h0);
      rd_chk(8'h00);
      for (int i = 0; i < 3; i++) begin
        a = (i == 0) ? (org16 ? 8'h7f : 8'hff) : 8'($urandom_range(0, org16 ? 127 : 255));
        prog(OP_WRITE, a, 16'($urandom));
        prog(OP_WRITE, a, 16'($urandom));
        rd_chk(a);
        rd_chk(a ^ 8'h01);
      end
      prog(OP_ERASE, a, 16'h0);
      rd_chk(a);
      prog(OP_MISC, sub_a(SUB_WRITE_EVERY_WORD_CMD), 16'($urandom));
      rd_chk(8'($urandom_range(0, org16 ? 127 : 255)));
      prog(OP_WRITE, a, 16'($urandom));
      cmd(OP_WRITE, a, 16'($urandom), $urandom_range(1, 9), rd);
      rd_chk(a);
      set_en(1'b0);
      prog(OP_WRITE, a, 16'($urandom));
      rd_chk(a);
      $display("test of width mode %0d done", m);
    end
    wrap_up();
  end
endmodule : serial_eeprom_command_port_test
